// ===== rcm_pkg.sv
// Package of constants for the retriggerable counter block
`default_nettype none
package rcm_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_RELOAD = 8'h04;
  localparam logic [7:0] OFF_CAPTURE = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // ==========================================================
  // Reset values
  localparam logic [15:0] MODE_RESET = 16'h0800;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  // ==========================================================
  // Mode field positions
  localparam int OUT_LSB = 0;
  localparam int BCD_BIT = 3;
  localparam int UP_BIT = 4;
  localparam int REPEAT_BIT = 5;
  localparam int RELOAD_SRC_BIT = 6;
  localparam int RETRIG_BIT = 7;
  localparam int SRC_SEL_LSB = 8;
  localparam int POLARITY_BIT = 12;
  localparam int GATING_LSB = 13;
  // ==========================================================
  // Output control codes
  localparam logic [2:0] OUT_LOW = 3'h0;
  localparam logic [2:0] OUT_TC_HIGH = 3'h1;
  localparam logic [2:0] OUT_TOGGLE = 3'h2;
  localparam logic [2:0] OUT_HIGHZ = 3'h4;
  localparam logic [2:0] OUT_TC_LOW = 3'h5;
  // ==========================================================
  // Gating codes
  localparam logic [2:0] GATE_NONE = 3'h0;
  localparam logic [2:0] GATE_LVL_LOW = 3'h5;
  localparam logic [2:0] GATE_EDGE_RISE = 3'h6;
  localparam logic [2:0] GATE_EDGE_FALL = 3'h7;
  // ==========================================================
  // Command bits
  localparam int CMD_ARM = 0;
  localparam int CMD_PRESET = 1;
  localparam int CMD_PRESET_ARM = 2;
  localparam int CMD_DISARM = 3;
  localparam int CMD_SET_OUT = 4;
  localparam int CMD_CLEAR_OUT = 5;
  localparam int CMD_MASTER_RESET = 6;
  // ==========================================================
  // Sources and timing
  localparam int SRC_PINS = 5;
  localparam int GATE_PINS = 5;
  localparam int PIN_COUNT = SRC_PINS + GATE_PINS;
  localparam int FREQ_COUNT = 5;
  localparam int FREQ_STEP_BITS = 4;
  localparam int PRE_WIDTH = FREQ_COUNT * FREQ_STEP_BITS;
  localparam int OWN_GATE_SLOT = 6;
  localparam int F1_SLOT = 8;
endpackage
`default_nettype wire

// ===== rcm_counter.sv
// One retriggerable general counter with its APB register slave
`default_nettype none
module rcm_counter (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Count sources and gates
  input wire logic [rcm_pkg::SRC_PINS-1:0] SRC_PIN,
  input wire logic [rcm_pkg::GATE_PINS-1:0] GATE_PIN,
  input wire logic TC_PREV,
  // Counter output pin
  output logic CTR_OUT,
  output logic CTR_OUT_OE,
  output logic TERMINAL_COUNT
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] mode_q;
    logic [15:0] reload_q;
    logic [15:0] capture_q;
    logic [15:0] count_q;
    logic armed_q;
    logic running_q;
    logic pend_q;
    logic tc_q;
    logic tog_q;
    logic out_q;
    logic oe_q;
    logic [31:0] prdata_q;
    logic slverr_q;
    logic [rcm_pkg::PIN_COUNT-1:0] sync1_q;
    logic [rcm_pkg::PIN_COUNT-1:0] sync2_q;
    logic [15:0] hist_q;
    logic [rcm_pkg::PRE_WIDTH-1:0] pre_q;
  } rcm_state_t;

  rcm_state_t s;
  rcm_state_t n;

  // ==========================================================
  // Count step for binary and decimal, both directions
  function automatic logic [15:0] rcm_step(input logic [15:0] v, input logic up,
                                           input logic bcd);
    logic [15:0] r;
    logic [3:0] d;
    logic carry;
    r = v;
    carry = 1'b1;
    if (!bcd) begin
      r = up ? v + 16'h0001 : v - 16'h0001;
    end else begin
      for (int i = 0; i < 4; i++) begin
        d = v[4*i +: 4];
        if (carry) begin
          if (up) begin
            if (d == 4'h9) begin
              d = 4'h0;
            end else begin
              d = d + 4'h1;
              carry = 1'b0;
            end
          end else begin
            if (d == 4'h0) begin
              d = 4'h9;
            end else begin
              d = d - 4'h1;
              carry = 1'b0;
            end
          end
        end
        r[4*i +: 4] = d;
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Source and gate decode
  logic [15:0] lv;
  logic [rcm_pkg::FREQ_COUNT-1:0] fsq;
  logic [2:0] gfield;
  logic [3:0] ssel;
  logic pol;
  logic src_edge;
  logic gate_act;
  logic gate_act_prev;
  logic gate_edge;
  logic edge_mode;
  logic level_mode;
  logic retrig_en;
  logic qual;
  logic cnt_step;
  logic at_term;
  logic cmd_wr;
  logic apb_wr;
  logic [31:0] rd_mux;
  logic rd_err;

  genvar gi;
  generate
    for (gi = 0; gi < rcm_pkg::FREQ_COUNT; gi++) begin : g_freq
      // Square waves, each sixteen times slower than the one before
      assign fsq[gi] = s.pre_q[rcm_pkg::FREQ_STEP_BITS*(gi+1)-1];
    end
  endgenerate

  assign gfield = s.mode_q[rcm_pkg::GATING_LSB +: 3];
  assign ssel = s.mode_q[rcm_pkg::SRC_SEL_LSB +: 4];
  assign pol = s.mode_q[rcm_pkg::POLARITY_BIT];
  // SRC_PIN and GATE_PIN enter only through the second synchroniser stage; TC_PREV enters directly
  assign lv = {s.sync2_q[9:7], fsq, s.sync2_q[6:5], s.sync2_q[4:0], TC_PREV};
  assign src_edge = pol ? (s.hist_q[ssel] & ~lv[ssel]) : (lv[ssel] & ~s.hist_q[ssel]);
  assign gate_act = (gfield == rcm_pkg::GATE_LVL_LOW || gfield == rcm_pkg::GATE_EDGE_FALL)
                    ? ~lv[rcm_pkg::OWN_GATE_SLOT] : lv[rcm_pkg::OWN_GATE_SLOT];
  assign gate_act_prev = (gfield == rcm_pkg::GATE_LVL_LOW || gfield == rcm_pkg::GATE_EDGE_FALL)
                    ? ~s.hist_q[rcm_pkg::OWN_GATE_SLOT] : s.hist_q[rcm_pkg::OWN_GATE_SLOT];
  assign gate_edge = gate_act & ~gate_act_prev;
  assign edge_mode = (gfield == rcm_pkg::GATE_EDGE_RISE) || (gfield == rcm_pkg::GATE_EDGE_FALL);
  assign level_mode = (gfield != rcm_pkg::GATE_NONE) && !edge_mode;
  assign retrig_en = (gfield != rcm_pkg::GATE_NONE) && s.mode_q[rcm_pkg::RETRIG_BIT];

  always_comb begin
    if (gfield == rcm_pkg::GATE_NONE) begin
      qual = s.armed_q;
    end else if (level_mode) begin
      qual = s.armed_q && gate_act;
    end else begin
      qual = s.armed_q && s.running_q;
    end
  end

  // A counter in terminal count always takes the next edge
  assign cnt_step = src_edge && (s.tc_q || qual);
  always_comb begin
    if (s.mode_q[rcm_pkg::UP_BIT]) begin
      at_term = s.mode_q[rcm_pkg::BCD_BIT] ? (s.count_q == 16'h9999)
                                           : (s.count_q == 16'hffff);
    end else begin
      at_term = (s.count_q == 16'h0001);
    end
  end

  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign cmd_wr = apb_wr && (PADDR == rcm_pkg::OFF_CMD);

  always_comb begin
    rd_err = 1'b0;
    unique case (PADDR)
      rcm_pkg::OFF_MODE: rd_mux = {16'h0000, s.mode_q};
      rcm_pkg::OFF_RELOAD: rd_mux = {16'h0000, s.reload_q};
      rcm_pkg::OFF_CAPTURE: rd_mux = {16'h0000, s.capture_q};
      rcm_pkg::OFF_COUNT: rd_mux = {16'h0000, s.count_q};
      rcm_pkg::OFF_CMD: rd_mux = 32'h00000000;
      rcm_pkg::OFF_STATUS: rd_mux = {27'h0000000, s.tc_q, s.tog_q, s.running_q,
                                     s.pend_q, s.armed_q};
      default: begin
        rd_mux = 32'h00000000;
        rd_err = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    n = s;
    n.sync1_q = {GATE_PIN, SRC_PIN};
    n.sync2_q = s.sync1_q;
    n.hist_q = lv;
    n.pre_q = s.pre_q + {{(rcm_pkg::PRE_WIDTH-1){1'b0}}, 1'b1};
    // Read data is latched in the setup cycle, so the access cycle ends at once
    if (PSEL && !PENABLE) begin
      n.prdata_q = PWRITE ? 32'h00000000 : rd_mux;
      n.slverr_q = rd_err;
    end
    // Counting
    if (cnt_step) begin
      if (s.pend_q && !s.tc_q) begin
        n.count_q = s.reload_q;
        n.pend_q = 1'b0;
      end else if (at_term) begin
        n.count_q = s.reload_q;
        n.tc_q = 1'b1;
        if (s.tc_q) begin
          n.tog_q = ~s.tog_q;
        end
      end else begin
        n.count_q = rcm_step(s.count_q, s.mode_q[rcm_pkg::UP_BIT], s.mode_q[rcm_pkg::BCD_BIT]);
        if (s.tc_q) begin
          n.tc_q = 1'b0;
          n.tog_q = ~s.tog_q;
          // Stopping waits for the edge that ends terminal count
          if (edge_mode) begin
            n.running_q = 1'b0;
          end else if (!s.mode_q[rcm_pkg::REPEAT_BIT]) begin
            n.armed_q = 1'b0;
          end
        end
      end
    end
    // Gate edges
    if (s.armed_q && gate_edge && gfield != rcm_pkg::GATE_NONE) begin
      if (retrig_en) begin
        n.capture_q = s.count_q;
        n.pend_q = 1'b1;
        if (edge_mode) begin
          n.running_q = 1'b1;
        end
      end else if (edge_mode) begin
        if (s.running_q) begin
          n.capture_q = s.count_q;
        end else begin
          n.running_q = 1'b1;
        end
      end
    end
    // Register writes
    if (apb_wr && PADDR == rcm_pkg::OFF_MODE) begin
      n.mode_q = PWDATA[15:0];
    end
    if (apb_wr && PADDR == rcm_pkg::OFF_RELOAD) begin
      n.reload_q = PWDATA[15:0];
    end
    if (cmd_wr) begin
      if (PWDATA[rcm_pkg::CMD_PRESET] || PWDATA[rcm_pkg::CMD_PRESET_ARM]) begin
        n.count_q = s.reload_q;
        n.tc_q = 1'b0;
        n.pend_q = 1'b0;
      end
      if (PWDATA[rcm_pkg::CMD_ARM] || PWDATA[rcm_pkg::CMD_PRESET_ARM]) begin
        n.armed_q = 1'b1;
      end
      if (PWDATA[rcm_pkg::CMD_DISARM]) begin
        n.armed_q = 1'b0;
        n.running_q = 1'b0;
      end
      if (PWDATA[rcm_pkg::CMD_SET_OUT]) begin
        n.tog_q = 1'b1;
      end
      if (PWDATA[rcm_pkg::CMD_CLEAR_OUT]) begin
        n.tog_q = 1'b0;
      end
      if (PWDATA[rcm_pkg::CMD_MASTER_RESET]) begin
        n.mode_q = rcm_pkg::MODE_RESET;
        n.armed_q = 1'b0;
        n.running_q = 1'b0;
        n.pend_q = 1'b0;
        n.tc_q = 1'b0;
      end
    end
    // Output pin
    unique case (n.mode_q[rcm_pkg::OUT_LSB +: 3])
      rcm_pkg::OUT_TC_HIGH: n.out_q = n.tc_q;
      rcm_pkg::OUT_TC_LOW: n.out_q = ~n.tc_q;
      rcm_pkg::OUT_TOGGLE: n.out_q = n.tog_q;
      default: n.out_q = 1'b0;
    endcase
    n.oe_q = n.mode_q[rcm_pkg::OUT_LSB +: 3] != rcm_pkg::OUT_HIGHZ;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      s <= '0;
      s.mode_q <= rcm_pkg::MODE_RESET;
      s.reload_q <= rcm_pkg::RELOAD_RESET;
      s.oe_q <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign PRDATA = s.prdata_q;
  assign PREADY = 1'b1;
  assign PSLVERR = s.slverr_q && PSEL && PENABLE;
  assign CTR_OUT = s.out_q;
  assign CTR_OUT_OE = s.oe_q;
  assign TERMINAL_COUNT = s.tc_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  mode_reset_a: assert property (disable iff (1'b0) !RST_N |=> s.mode_q == 16'h0800)
    else $error("mode register not at reset value");
  armed_step_a: assert property (cnt_step |-> (s.tc_q || s.armed_q))
    else $error("count step while disarmed");
  level_gate_a: assert property (level_mode && !s.tc_q && !gate_act && !cmd_wr
                                 |=> $stable(s.count_q))
    else $error("count moved with gate inactive");
  tc_reload_a: assert property (cnt_step && at_term && !(s.pend_q && !s.tc_q) && !cmd_wr
                                |=> s.tc_q && s.count_q == $past(s.reload_q))
    else $error("terminal count did not reload");
  retrig_cap_a: assert property (s.armed_q && retrig_en && gate_edge
                                 |=> s.capture_q == $past(s.count_q) && s.pend_q)
    else $error("retrigger did not capture count");
  pend_load_a: assert property (s.pend_q && !s.tc_q && cnt_step && !gate_edge && !cmd_wr
                                |=> !s.pend_q && s.count_q == $past(s.reload_q))
    else $error("first edge after retrigger did not load");
  edge_ignore_a: assert property (edge_mode && !s.armed_q && !s.running_q && !cmd_wr
                                  |=> !s.running_q)
    else $error("disarmed counter started on gate edge");
  tc_width_a: assert property (s.tc_q && src_edge && !at_term && !cmd_wr |=> !s.tc_q)
    else $error("terminal count outlived one source period");
  toggle_flip_a: assert property (s.tc_q && src_edge && !cmd_wr
                                  |=> s.tog_q != $past(s.tog_q))
    else $error("toggle did not flip at end of terminal count");
  sample_cap_a: assert property (edge_mode && !retrig_en && s.armed_q && s.running_q && gate_edge
                                 && !cnt_step |=> s.capture_q == $past(s.count_q)
                                 && $stable(s.count_q))
    else $error("sample edge disturbed count");
  set_out_a: assert property (cmd_wr && PWDATA[rcm_pkg::CMD_SET_OUT]
                              && !PWDATA[rcm_pkg::CMD_CLEAR_OUT] |=> s.tog_q)
    else $error("set output command ignored");
  mreset_mode_a: assert property (cmd_wr && PWDATA[rcm_pkg::CMD_MASTER_RESET]
                                  |=> s.mode_q == rcm_pkg::MODE_RESET)
    else $error("master reset left mode register unchanged");
  oe_match_a: assert property (s.oe_q
                               == (s.mode_q[rcm_pkg::OUT_LSB +: 3] != rcm_pkg::OUT_HIGHZ))
    else $error("output enable does not follow output code");
  up_term_a: assert property (cnt_step && s.mode_q[rcm_pkg::UP_BIT]
                              && s.mode_q[rcm_pkg::BCD_BIT] && s.count_q == 16'h9999
                              && !s.pend_q && !cmd_wr
                              |=> s.tc_q && s.count_q == $past(s.reload_q))
    else $error("decimal up count missed terminal count");
  src_polarity_a: assert property (src_edge |-> lv[ssel] != pol && s.hist_q[ssel] == pol)
    else $error("source edge of wrong polarity");
  disarm_stop_a: assert property (cmd_wr && PWDATA[rcm_pkg::CMD_DISARM]
                                  && !PWDATA[rcm_pkg::CMD_ARM] && !PWDATA[rcm_pkg::CMD_PRESET_ARM]
                                  |=> !s.armed_q && !s.running_q)
    else $error("disarm command did not stop counter");

  retrig_c: cover property (s.pend_q && cnt_step ##[1:50] s.tc_q);
  sample_c: cover property (s.running_q && gate_edge && !retrig_en);
  toggle_c: cover property (s.tc_q ##1 !s.tc_q ##[1:100] s.tc_q);
  bcd_up_c: cover property (s.mode_q[rcm_pkg::UP_BIT] && s.mode_q[rcm_pkg::BCD_BIT] && at_term);
  one_shot_c: cover property (edge_mode && retrig_en && s.tc_q && cnt_step);
endmodule
`default_nettype wire

// ===== rcm_far_end.sv
// Far-side model: source pulse shaper, gate driver and idle pin noise
`default_nettype none
module rcm_far_end (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Bench control
  input wire logic step,
  input wire logic gate_lvl,
  output logic busy,
  // Pins
  output logic [4:0] SRC_PIN,
  output logic [4:0] GATE_PIN,
  output logic TC_PREV
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ph_q;
  logic [7:0] noise_q;
  // ==========================================================
  // Pulse
  // Four cycles high so the two-stage synchroniser cannot miss it
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ph_q <= 4'h0;
      noise_q <= 8'h5a;
    end else begin
      noise_q <= noise_q + 8'h3b;
      if (ph_q != 4'h0) begin
        ph_q <= (ph_q == 4'h8) ? 4'h0 : ph_q + 4'h1;
      end else if (step) begin
        ph_q <= 4'h1;
      end
    end
  end
  // Unselected pins keep changing so a wrong select shows up
  assign busy = (ph_q != 4'h0);
  assign SRC_PIN = {noise_q[3:0], (ph_q != 4'h0) && (ph_q < 4'h5)};
  assign GATE_PIN = {noise_q[7:4], gate_lvl};
  assign TC_PREV = noise_q[0];
endmodule
`default_nettype wire

// ===== retriggerable_counter_modes_test.sv
// Self-checking bench for the retriggerable counter
`default_nettype none
module retriggerable_counter_modes_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ctr_out, ctr_oe, tc, busy, tc_prev, perr;
  logic step = 1'b0;
  logic gate = 1'b0;
  logic [4:0] src_pin, gate_pin;
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h840d;
  logic [31:0] rd, reload, cnt;
  logic exp_tc, tog, pend, run, one_shot;
  logic [4:0] tbl [5] = '{5'b000_1_0, 5'b100_0_0, 5'b001_1_0, 5'b101_1_1, 5'b010_1_1};

  rcm_counter dut (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SRC_PIN(src_pin), .GATE_PIN(gate_pin), .TC_PREV(tc_prev),
    .CTR_OUT(ctr_out), .CTR_OUT_OE(ctr_oe), .TERMINAL_COUNT(tc));
  rcm_far_end far (.CLK_SYS(clk), .RST_N(rst_n), .step(step), .gate_lvl(gate), .busy(busy),
    .SRC_PIN(src_pin), .GATE_PIN(gate_pin), .TC_PREV(tc_prev));

  initial begin
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Master waits for pready under a bound, data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, pready, 1'b1);
      stop_test();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic cmd(input int b);
    apb(1'b1, rcm_pkg::OFF_CMD, 32'h1 << b);
  endtask
  task automatic set_gate(input logic v);
    @(posedge clk);
    gate <= v;
    repeat (6) @(posedge clk);
  endtask
  // Expected effect of one counted source edge
  task automatic model();
    logic was;
    if (pend) begin
      cnt = reload;
      pend = 1'b0;
    end else begin
      was = exp_tc;
      exp_tc = (cnt == 32'h1);
      cnt = exp_tc ? reload : cnt - 32'h1;
      if (was) begin
        tog = ~tog;
        if (one_shot) run = 1'b0;
      end
    end
  endtask
  task automatic pulse(input logic counts);
    int n;
    @(posedge clk);
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    n = 0;
    @(posedge clk);
    while (busy === 1'b1 && n < 40) begin
      n++;
      @(posedge clk);
    end
    if (n >= 40) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, busy, 1'b0);
      stop_test();
    end
    repeat (2) @(posedge clk);
    if (counts) model();
    rdc(rcm_pkg::OFF_COUNT, cnt);
    chk({31'h0, tc}, {31'h0, exp_tc});
    chk({31'h0, ctr_out}, {31'h0, tog});
  endtask
  // Host keeps the counter disarmed while the mode changes
  task automatic cfg(input logic [15:0] m, input logic os);
    // Gate left high by an earlier test would qualify edges in level modes
    set_gate(1'b0);
    seed = xs(seed);
    reload = {29'h0, seed[2:0]} + 32'h2;
    cmd(rcm_pkg::CMD_DISARM);
    apb(1'b1, rcm_pkg::OFF_MODE, {16'h0, m});
    apb(1'b1, rcm_pkg::OFF_RELOAD, reload);
    cmd(rcm_pkg::CMD_PRESET);
    cmd(rcm_pkg::CMD_CLEAR_OUT);
    cnt = reload;
    {exp_tc, tog, pend, run, one_shot} = {4'h0, os};
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdc(rcm_pkg::OFF_MODE, 32'h0800);
    chk({31'h0, ctr_oe}, 32'h1);
    rdc(8'h20, 32'h0);
    chk({31'h0, perr}, 32'h1);
    apb(1'b1, rcm_pkg::OFF_MODE, 32'h21a2);
    cmd(rcm_pkg::CMD_MASTER_RESET);
    rdc(rcm_pkg::OFF_MODE, 32'h0800);
    $display("test reset done");
    cmd(rcm_pkg::CMD_SET_OUT);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, rcm_pkg::OFF_MODE, {16'h0, 13'h0100, tbl[i][4:2]});
      repeat (2) @(posedge clk);
      chk({30'h0, ctr_oe, ctr_out}, {30'h0, tbl[i][1:0]});
    end
    cmd(rcm_pkg::CMD_CLEAR_OUT);
    repeat (2) @(posedge clk);
    chk({31'h0, ctr_out}, 32'h0);
    $display("test output done");
    cfg(16'h0122, 1'b0);
    cmd(rcm_pkg::CMD_ARM);
    rdc(rcm_pkg::OFF_STATUS, 32'h1);
    for (int i = 0; i < 32'(reload) + 1; i++) begin
      seed = xs(seed);
      gate <= seed[4];
      pulse(1'b1);
    end
    while (exp_tc !== 1'b1) pulse(1'b1);
    cmd(rcm_pkg::CMD_DISARM);
    pulse(1'b1);
    pulse(1'b0);
    $display("test free count done");
    cfg(16'h21a2, 1'b0);
    pulse(1'b0);
    cmd(rcm_pkg::CMD_ARM);
    pulse(1'b0);
    for (int k = 0; k < 2; k++) begin
      set_gate(1'b1);
      pend = 1'b1;
      rdc(rcm_pkg::OFF_CAPTURE, cnt);
      pulse(1'b1);
      for (int i = 0; i < 32'(reload); i++) pulse(1'b1);
      set_gate(1'b0);
      pulse(1'b1);
      pulse(1'b0);
    end
    $display("test level retrigger done");
    cfg(16'hc1a2, 1'b1);
    set_gate(1'b1);
    pulse(1'b0);
    set_gate(1'b0);
    cmd(rcm_pkg::CMD_ARM);
    for (int k = 0; k < 2; k++) begin
      set_gate(1'b1);
      {run, pend} = 2'b11;
      rdc(rcm_pkg::OFF_CAPTURE, cnt);
      set_gate(1'b0);
      for (int i = 0; i < 20 && run; i++) pulse(1'b1);
      pulse(1'b0);
    end
    $display("test one-shot done");
    cfg(16'hc122, 1'b1);
    cmd(rcm_pkg::CMD_PRESET_ARM);
    pulse(1'b0);
    for (int k = 0; k < 2; k++) begin
      set_gate(1'b1);
      run = 1'b1;
      set_gate(1'b0);
      pulse(1'b1);
      if (!exp_tc) begin
        set_gate(1'b1);
        rdc(rcm_pkg::OFF_CAPTURE, cnt);
        set_gate(1'b0);
      end
      for (int i = 0; i < 20 && run; i++) pulse(1'b1);
      pulse(1'b0);
    end
    $display("test sampling done");
    cfg(16'h113a, 1'b0);
    apb(1'b1, rcm_pkg::OFF_RELOAD, 32'h9998);
    cmd(rcm_pkg::CMD_PRESET_ARM);
    cnt = 32'h9999;
    pulse(1'b0);
    {cnt, exp_tc} = {32'h9998, 1'b1};
    pulse(1'b0);
    {cnt, exp_tc, tog} = {32'h9999, 1'b0, 1'b1};
    pulse(1'b0);
    $display("test up count done");
    stop_test();
  end
endmodule
`default_nettype wire
